// [verilog/can_status_defs.svh]
/*
 * can_status_defs.svh: register offsets, field positions, reset values and counts
 * for the status and interrupt flag block.
 * Assumes a 32-bit APB slave where each register takes one aligned word.
 */
`ifndef CAN_STATUS_DEFS_SVH
`define CAN_STATUS_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define CTRL_IDX         4'h0
`define CMD_IDX          4'h1
`define STATUS_IDX       4'h2
`define IRQ_FLAGS_IDX    4'h3
`define ADDR_W           12
`define CTRL_ADDR        12'h000
`define CMD_ADDR         12'h004
`define STATUS_ADDR      12'h008
`define IRQ_FLAGS_ADDR   12'h00C

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTRL_HALT        0
`define CTRL_RX_IE       1
`define CTRL_TX_IE       2
`define CTRL_ERR_IE      3
`define CTRL_OVR_IE      4
`define CTRL_RESET       8'h01

// ----------------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------------
`define CMD_SEND         0
`define CMD_ABORT        1
`define CMD_RX_FREE      2
`define CMD_CLR_OVR      3
`define CMD_READ_VALUE   8'hFF

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define ST_RX_FULL       0
`define ST_OVERRUN       1
`define ST_TX_FREE       2
`define ST_TX_DONE       3
`define ST_RX_ACTIVE     4
`define ST_TX_ACTIVE     5
`define ST_WARN          6
`define ST_OFF_BUS       7

// ----------------------------------------------------------------------------
// interrupt flag fields
// ----------------------------------------------------------------------------
`define IRQ_RX           0
`define IRQ_TX           1
`define IRQ_FAULT        2
`define IRQ_OVR          3
`define IRQ_WAKE         4

// ----------------------------------------------------------------------------
// bus-off recovery
// ----------------------------------------------------------------------------
`define BUS_FREE_COUNT   8'd128

`endif

// [verilog/can_status_pkg.sv]
/*
 * can_status_pkg.sv: types shared by the status and interrupt flag block.
 * Assumes can_status_defs.svh supplies the numeric constants.
 */
`default_nettype none
package can_status_pkg;

  typedef enum logic [1:0] {
    BUS_ON      = 2'b00,
    OFF_HALTED  = 2'b01,
    OFF_COUNT   = 2'b10
  } bus_state_e;

endpackage : can_status_pkg
`default_nettype wire

// [verilog/can_status_irq_logic.sv]
/*
 * can_status_irq_logic.sv: status flags, bus-off recovery and read-clear
 * interrupt flags of a stand-alone CAN controller, with an APB register slave.
 * Assumes the protocol engine on the same clock supplies one-cycle event strobes
 * and levels; pins pass through two-flop synchronisers.
 */
`timescale 1ns/1ps
`include "can_status_defs.svh"
`default_nettype none
module can_status_irq_logic (
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  // apb slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // protocol engine events, same clock, except wake_in which is synchronised
  input  wire logic                msg_start_in,
  input  wire logic                msg_byte_req_in,
  input  wire logic                msg_stored_in,
  input  wire logic                tx_ok_in,
  input  wire logic                tx_started_in,
  input  wire logic                rx_busy_in,
  input  wire logic                tx_busy_in,
  input  wire logic                warn_limit_in,
  input  wire logic                bus_off_in,
  input  wire logic                bus_free_in,
  input  wire logic                wake_in,
  input  wire logic                tbuf_wr_in,
  // pins
  output logic                     irq_n_pin_out,
  // to protocol engine
  output logic                     halt_req_out,
  output logic                     send_req_out,
  output logic                     tbuf_wr_en_out,
  output logic                     drop_msg_out,
  output logic                     err_cnt_clr_out
);

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  assign acc   = psel_in && penable_in;
  assign wr    = acc && pwrite_in;
  assign rd    = acc && !pwrite_in;
  assign wbyte = pwdata_in[7:0];

  logic ctrl_wr;
  logic cmd_wr;
  logic irq_rd;
  assign ctrl_wr = wr && (paddr_in == `CTRL_ADDR);
  assign cmd_wr  = wr && (paddr_in == `CMD_ADDR);
  assign irq_rd  = rd && (paddr_in == `IRQ_FLAGS_ADDR);

  logic send_cmd;
  logic abort_cmd;
  logic rx_free_cmd;
  logic clear_ovr_cmd;
  assign send_cmd      = cmd_wr && wbyte[`CMD_SEND];
  assign abort_cmd     = cmd_wr && wbyte[`CMD_ABORT];
  assign rx_free_cmd   = cmd_wr && wbyte[`CMD_RX_FREE];
  assign clear_ovr_cmd = cmd_wr && wbyte[`CMD_CLR_OVR];

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0]                ctrl_q;
  logic [1:0]                bufs_q;
  logic                      rx_full_q;
  logic                      overrun_q;
  logic                      tx_free_q;
  logic                      tx_done_q;
  logic                      tx_pend_q;
  logic                      tx_run_q;
  logic                      rx_act_q;
  logic                      tx_act_q;
  logic                      warn_q;
  logic                      off_bus_q;
  logic                      dropping_q;
  logic [4:0]                irq_q;
  logic [7:0]                free_cnt_q;
  can_status_pkg::bus_state_e bus_q;
  logic                      wake_s1_q;
  logic                      wake_s2_q;
  logic                      wake_s3_q;

  // wake arrives from the sleeping oscillator domain
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_in;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  logic wake_ev;
  assign wake_ev = wake_s2_q && !wake_s3_q;

  // --------------------------------------------------------------------------
  // receive buffers and overrun
  // --------------------------------------------------------------------------
  logic ovr_ev;
  logic store_ev;
  assign ovr_ev   = msg_byte_req_in && !dropping_q && (bufs_q == 2'd2);
  assign store_ev = msg_stored_in && !dropping_q && !ovr_ev;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dropping_q <= 1'b0;
    end else if (msg_start_in) begin
      dropping_q <= 1'b0;
    end else if (ovr_ev) begin
      dropping_q <= 1'b1;
    end
  end

  assign drop_msg_out = dropping_q;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bufs_q <= 2'd0;
    end else begin
      case ({store_ev, rx_free_cmd && bufs_q != 2'd0})
        2'b10:   bufs_q <= bufs_q + 2'd1;
        2'b01:   bufs_q <= bufs_q - 2'd1;
        default: bufs_q <= bufs_q;
      endcase
    end
  end

  // rx full tracks whether the host-side buffer holds a message
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_full_q <= 1'b0;
    end else if (store_ev) begin
      rx_full_q <= 1'b1;
    end else if (rx_free_cmd) begin
      rx_full_q <= (bufs_q == 2'd2);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overrun_q <= 1'b0;
    end else if (ovr_ev) begin
      overrun_q <= 1'b1;
    end else if (clear_ovr_cmd) begin
      overrun_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // transmit buffer
  // --------------------------------------------------------------------------
  logic tx_release_ev;
  assign tx_release_ev = !tx_free_q && ((tx_run_q && tx_ok_in) || (abort_cmd && !tx_run_q));

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pend_q <= 1'b0;
      tx_run_q  <= 1'b0;
      tx_free_q <= 1'b1;
      tx_done_q <= 1'b1;
    end else begin
      if (send_cmd && tx_free_q) begin
        tx_pend_q <= 1'b1;
        tx_free_q <= 1'b0;
        tx_done_q <= 1'b0;
      end else if (abort_cmd && tx_pend_q && !tx_run_q) begin
        tx_pend_q <= 1'b0;
        tx_free_q <= 1'b1;
      end else if (tx_pend_q && !tx_run_q && tx_started_in) begin
        tx_run_q <= 1'b1;
      end else if (tx_run_q && tx_ok_in) begin
        tx_run_q  <= 1'b0;
        tx_pend_q <= 1'b0;
        tx_free_q <= 1'b1;
        tx_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tbuf_wr_en_out <= 1'b0;
      send_req_out   <= 1'b0;
    end else begin
      tbuf_wr_en_out <= tbuf_wr_in && tx_free_q;
      send_req_out   <= tx_pend_q && !tx_run_q;
    end
  end

  // --------------------------------------------------------------------------
  // activity and error state
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_act_q <= 1'b0;
      tx_act_q <= 1'b0;
    end else begin
      rx_act_q <= rx_busy_in;
      tx_act_q <= tx_busy_in;
    end
  end

  logic warn_d;
  logic off_d;
  logic recover;
  assign recover = (bus_q == can_status_pkg::OFF_COUNT) && bus_free_in &&
                   (free_cnt_q == `BUS_FREE_COUNT - 8'd1);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_q      <= can_status_pkg::BUS_ON;
      free_cnt_q <= 8'd0;
    end else begin
      unique case (bus_q)
        can_status_pkg::BUS_ON: begin
          if (bus_off_in) begin
            bus_q <= can_status_pkg::OFF_HALTED;
          end
        end
        can_status_pkg::OFF_HALTED: begin
          free_cnt_q <= 8'd0;
          if (!ctrl_q[`CTRL_HALT]) begin
            bus_q <= can_status_pkg::OFF_COUNT;
          end
        end
        can_status_pkg::OFF_COUNT: begin
          if (recover) begin
            bus_q <= can_status_pkg::BUS_ON;
          end else if (bus_free_in) begin
            free_cnt_q <= free_cnt_q + 8'd1;
          end
        end
        default: bus_q <= can_status_pkg::BUS_ON;
      endcase
    end
  end

  assign off_d  = (bus_q != can_status_pkg::BUS_ON) || bus_off_in;
  assign warn_d = recover ? 1'b0 : warn_limit_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warn_q          <= 1'b0;
      off_bus_q       <= 1'b0;
      err_cnt_clr_out <= 1'b0;
    end else begin
      warn_q          <= warn_d;
      off_bus_q       <= recover ? 1'b0 : off_d;
      err_cnt_clr_out <= recover;
    end
  end

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= {3'h0, wbyte[4:0]};
      end
      if (bus_q == can_status_pkg::BUS_ON && bus_off_in) begin
        ctrl_q[`CTRL_HALT] <= 1'b1;
      end
    end
  end

  assign halt_req_out = ctrl_q[`CTRL_HALT];

  // --------------------------------------------------------------------------
  // interrupt flags
  // --------------------------------------------------------------------------
  logic [4:0] irq_set;
  logic       err_change;
  assign err_change = (warn_d != warn_q) || ((recover ? 1'b0 : off_d) != off_bus_q);

  always_comb begin
    irq_set             = 5'h00;
    irq_set[`IRQ_RX]    = store_ev && ctrl_q[`CTRL_RX_IE];
    irq_set[`IRQ_TX]    = tx_release_ev && ctrl_q[`CTRL_TX_IE];
    irq_set[`IRQ_FAULT] = err_change && ctrl_q[`CTRL_ERR_IE];
    irq_set[`IRQ_OVR]   = ovr_ev && ctrl_q[`CTRL_OVR_IE];
    irq_set[`IRQ_WAKE]  = wake_ev;
  end

  // a read clears only the bits it returned; bits set since setup stay
  logic [4:0] irq_d;
  assign irq_d = irq_rd ? ((irq_q & ~prdata_out[4:0]) | irq_set) : (irq_q | irq_set);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 5'h00;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_n_pin_out <= 1'b1;
    end else begin
      irq_n_pin_out <= ~|irq_d;
    end
  end

  // --------------------------------------------------------------------------
  // apb read data and answer
  // --------------------------------------------------------------------------
  logic [7:0] status;
  assign status = {off_bus_q, warn_q, tx_act_q, rx_act_q,
                   tx_done_q, tx_free_q, overrun_q, rx_full_q};

  logic [7:0] rbyte;
  logic       mapped;
  always_comb begin
    rbyte  = 8'h00;
    mapped = 1'b1;
    unique case (paddr_in)
      `CTRL_ADDR:      rbyte = ctrl_q;
      `CMD_ADDR:       rbyte = `CMD_READ_VALUE;
      `STATUS_ADDR:    rbyte = status;
      `IRQ_FLAGS_ADDR: rbyte = {3'h0, irq_q};
      default:         mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? {24'h000000, rbyte}
                                                             : 32'h00000000;
    end
  end

endmodule : can_status_irq_logic
`default_nettype wire

// [testbench/can_status_irq_monitor.sv]
/* can_status_irq_monitor: port-level assertions for can_status_irq_logic.
   Assumes one clock domain and the async active-low reset of the block. */
`timescale 1ns/1ps
`include "can_status_defs.svh"
`default_nettype none
module can_status_irq_monitor (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        msg_start_in,
  input wire logic        msg_byte_req_in,
  input wire logic        msg_stored_in,
  input wire logic        tx_ok_in,
  input wire logic        bus_off_in,
  input wire logic        bus_free_in,
  input wire logic        wake_in,
  input wire logic        tbuf_wr_in,
  input wire logic        irq_n_pin_out,
  input wire logic        halt_req_out,
  input wire logic        send_req_out,
  input wire logic        tbuf_wr_en_out,
  input wire logic        drop_msg_out,
  input wire logic        err_cnt_clr_out
);
  // ----------------------------------------
  // bus-free events since halt was dropped
  // ----------------------------------------
  logic [8:0] bf_cnt_q;
  wire logic  acc = psel_in && penable_in && pready_out;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bf_cnt_q <= 9'h000;
    end else if (bus_off_in || halt_req_out) begin
      bf_cnt_q <= 9'h000;
    end else if (bus_free_in) begin
      bf_cnt_q <= bf_cnt_q + 9'h001;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no pready after setup");
  chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("pslverr outside access");
  chk_tbuf_locked: assert property (tbuf_wr_in && send_req_out &&
      !$past(acc && pwrite_in) |=> !tbuf_wr_en_out)
    else $error("tx buffer write passed while locked");
  chk_halt_on_off: assert property (bus_off_in |=> halt_req_out)
    else $error("halt not forced on bus-off");
  chk_halt_held: assert property (halt_req_out && !(acc && pwrite_in &&
      paddr_in == `CTRL_ADDR) |=> halt_req_out)
    else $error("halt dropped without host write");
  chk_read_clears_irq: assert property (acc && !pwrite_in &&
      paddr_in == `IRQ_FLAGS_ADDR && !(msg_stored_in || msg_byte_req_in || tx_ok_in ||
      bus_off_in || bus_free_in) && !$past(msg_stored_in || msg_byte_req_in || tx_ok_in ||
      bus_off_in || bus_free_in) |=> irq_n_pin_out)
    else $error("irq pin active after clearing read");
  chk_drop_held: assert property (drop_msg_out && !msg_start_in |=> drop_msg_out)
    else $error("drop released before next message");
  chk_drop_release: assert property (msg_start_in && !msg_byte_req_in |=>
      !drop_msg_out)
    else $error("drop not released at message start");
  chk_recover_count: assert property (err_cnt_clr_out |-> bf_cnt_q >= 9'd128)
    else $error("recovery before 128 bus-free events");
  chk_wake_irq_pin: assert property ($rose(wake_in) |-> ##[1:6] !irq_n_pin_out)
    else $error("no irq after wake");
  cov_overrun_drop: cover property ($rose(drop_msg_out));
  cov_recovery: cover property (err_cnt_clr_out);
  cov_locked_write: cover property (tbuf_wr_in && send_req_out);
endmodule : can_status_irq_monitor
bind can_status_irq_logic can_status_irq_monitor mon (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .msg_start_in(msg_start_in), .msg_byte_req_in(msg_byte_req_in),
  .msg_stored_in(msg_stored_in), .tx_ok_in(tx_ok_in), .bus_off_in(bus_off_in),
  .bus_free_in(bus_free_in), .wake_in(wake_in), .tbuf_wr_in(tbuf_wr_in),
  .irq_n_pin_out(irq_n_pin_out), .halt_req_out(halt_req_out), .send_req_out(send_req_out),
  .tbuf_wr_en_out(tbuf_wr_en_out), .drop_msg_out(drop_msg_out),
  .err_cnt_clr_out(err_cnt_clr_out));
`default_nettype wire

// [testbench/host_cpu_model.sv]
/* host_cpu_model: APB master standing in for the host processor.
   Assumes callers enter its task just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic        mclk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output var logic         psel_out,
  output var logic         penable_out,
  output var logic         pwrite_out,
  output var logic  [11:0] paddr_out,
  output var logic  [31:0] pwdata_out
);
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'hFFF;
    pwdata_out  = 32'hA5A5A5A5;
  end
  // ----------------------------------------
  // one transfer; released address and data lines show the inverse
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge mclk_in);
    penable_out <= 1'b1;
    @(posedge mclk_in);
    while (pready_in !== 1'b1) @(posedge mclk_in);
    q = prdata_in;
    e = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

// [testbench/can_status_irq_logic_tb_top.sv]
/* can_status_irq_logic_tb_top: register-level tests of the status block.
   Assumes the host model and the bound monitor are compiled beforehand. */
`timescale 1ns/1ps
`include "can_status_defs.svh"
`default_nettype none
module can_status_irq_logic_tb_top;
  localparam int START = 0, BYTE = 1, STORED = 2, TXOK = 3;
  localparam int TXST = 4, BOFF = 5, BFREE = 6, TBWR = 7;
  logic        mclk_in = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  pv      = 8'h00;
  logic        rx_busy = 1'b0, tx_busy = 1'b0, warn_lim = 1'b0, wake = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq_n, halt, send, tbw_en, drop, ecc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  int          n_mismatch = 0, checked = 0, n_tbw = 0, n_ecc = 0;
  always #2.5 mclk_in = ~mclk_in;
  host_cpu_model host (.mclk_in(mclk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  can_status_irq_logic dut (.mclk_in(mclk_in), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .msg_start_in(pv[START]), .msg_byte_req_in(pv[BYTE]), .msg_stored_in(pv[STORED]),
    .tx_ok_in(pv[TXOK]), .tx_started_in(pv[TXST]), .rx_busy_in(rx_busy),
    .tx_busy_in(tx_busy), .warn_limit_in(warn_lim), .bus_off_in(pv[BOFF]),
    .bus_free_in(pv[BFREE]), .wake_in(wake), .tbuf_wr_in(pv[TBWR]),
    .irq_n_pin_out(irq_n), .halt_req_out(halt), .send_req_out(send),
    .tbuf_wr_en_out(tbw_en), .drop_msg_out(drop), .err_cnt_clr_out(ecc));
  // output pulses counted as they pass
  always @(posedge mclk_in) begin
    if (tbw_en === 1'b1) n_tbw++;
    if (ecc === 1'b1) n_ecc++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    cmp(q, {24'h0, x});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask : wr
  task automatic pulse(input int i);
    @(posedge mclk_in);
    pv[i] <= 1'b1;
    @(posedge mclk_in);
    pv <= 8'h00;
  endtask : pulse
  task automatic lv(input logic r, input logic t, input logic w);
    @(posedge mclk_in);
    rx_busy  <= r;
    tx_busy  <= t;
    warn_lim <= w;
    repeat (3) @(posedge mclk_in);
  endtask : lv
  task automatic pin(input logic x);
    repeat (2) @(posedge mclk_in);
    cmp({31'h0, irq_n}, {31'h0, x});
  endtask : pin
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n <= 1'b1;
    rd(`CTRL_ADDR, 8'h01);
    rd(`CMD_ADDR, 8'hFF);
    rd(`STATUS_ADDR, 8'h0C);
    rd(`IRQ_FLAGS_ADDR, 8'h00);
    host.xfer(1'b0, 12'h040, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1);
    wr(`STATUS_ADDR, 8'hFF);
    rd(`STATUS_ADDR, 8'h0C);
    wr(`CTRL_ADDR, 8'h1E);
    pulse(START);
    pulse(BYTE);
    pulse(STORED);
    pin(1'b0);
    rd(`STATUS_ADDR, 8'h0D);
    rd(`IRQ_FLAGS_ADDR, 8'h01);
    pin(1'b1);
    rd(`IRQ_FLAGS_ADDR, 8'h00);
    pulse(START);
    pulse(BYTE);
    pulse(STORED);
    // third frame with both buffers full
    pulse(START);
    pulse(BYTE);
    @(posedge mclk_in);
    cmp({31'h0, drop}, 32'h1);
    pulse(STORED);
    rd(`STATUS_ADDR, 8'h0F);
    rd(`IRQ_FLAGS_ADDR, 8'h09);
    pulse(START);
    @(posedge mclk_in);
    cmp({31'h0, drop}, 32'h0);
    wr(`CMD_ADDR, 8'h0C);
    rd(`STATUS_ADDR, 8'h0D);
    wr(`CMD_ADDR, 8'h04);
    rd(`STATUS_ADDR, 8'h0C);
    pulse(TBWR);
    wr(`CMD_ADDR, 8'h01);
    rd(`STATUS_ADDR, 8'h00);
    cmp({31'h0, send}, 32'h1);
    pulse(TBWR);
    repeat (2) @(posedge mclk_in);
    cmp(n_tbw, 32'h1);
    pulse(TXST);
    pulse(TXOK);
    rd(`STATUS_ADDR, 8'h0C);
    rd(`IRQ_FLAGS_ADDR, 8'h02);
    wr(`CMD_ADDR, 8'h01);
    wr(`CMD_ADDR, 8'h02);
    rd(`STATUS_ADDR, 8'h04);
    rd(`IRQ_FLAGS_ADDR, 8'h02);
    lv(1'b1, 1'b1, 1'b1);
    rd(`STATUS_ADDR, 8'h74);
    rd(`IRQ_FLAGS_ADDR, 8'h04);
    lv(1'b0, 1'b0, 1'b0);
    rd(`STATUS_ADDR, 8'h04);
    rd(`IRQ_FLAGS_ADDR, 8'h04);
    pulse(BOFF);
    rd(`CTRL_ADDR, 8'h1F);
    rd(`STATUS_ADDR, 8'h84);
    rd(`IRQ_FLAGS_ADDR, 8'h04);
    wr(`CTRL_ADDR, 8'h1E);
    repeat (127) pulse(BFREE);
    rd(`STATUS_ADDR, 8'h84);
    cmp(n_ecc, 32'h0);
    pulse(BFREE);
    rd(`STATUS_ADDR, 8'h04);
    cmp(n_ecc, 32'h1);
    rd(`IRQ_FLAGS_ADDR, 8'h04);
    // message stored on the access edge of the clearing read
    fork
      rd(`IRQ_FLAGS_ADDR, 8'h00);
      begin
        @(posedge mclk_in);
        pulse(STORED);
      end
    join
    rd(`IRQ_FLAGS_ADDR, 8'h01);
    // message stored on the setup edge of the clearing read
    fork
      rd(`IRQ_FLAGS_ADDR, 8'h00);
      pulse(STORED);
    join
    rd(`IRQ_FLAGS_ADDR, 8'h01);
    @(posedge mclk_in);
    wake <= 1'b1;
    repeat (6) @(posedge mclk_in);
    rd(`IRQ_FLAGS_ADDR, 8'h10);
    report_and_stop();
  end
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : can_status_irq_logic_tb_top
`default_nettype wire
